// ==== core/bsc_sysctl_upper.v ====
// Upper half of the card-bridge system control configuration doubleword
`timescale 1ns/10ps
`include "bsc_defs.vh"

module bsc_sysctl_upper
(
  input  wire        ref_clk_i,
  input  wire        rst_n_i,
  input  wire [7:0]  cfg_addr_i,
  input  wire        cfg_func_i,
  input  wire        cfg_wr_i,
  input  wire [3:0]  cfg_be_i,
  input  wire [31:0] cfg_wdata_i,
  output reg  [31:0] cfg_rdata_o,
  // Internal interrupt lines and serial slots
  input  wire [2:0]  int_req_i,
  output wire [3:0]  serial_int_slot_o,
  output wire [2:0]  int_pin_report_o,
  output wire        switch_clock_o,
  output wire        switch_clock_oe_o,
  input  wire        osc_clk_i,
  // Socket power write events and interrupts
  input  wire [1:0]  power_write_i,
  output wire [1:0]  irq2_power_o,
  output wire [1:0]  card_status_change_irq_o,
  // Socket pin controls
  input  wire [1:0]  cardbus_inserted_i,
  output wire [1:0]  spare_terminal_oe_o,
  output wire [1:0]  vcc_guard_active_o,
  output wire [1:0]  card_addr_hi_oe_o,
  // Card DMA
  input  wire [1:0]  card_dreq_i,
  output wire [1:0]  dma_request_o,
  output wire [2:0]  card_dma_channel_o,
  output wire        card_dma_16bit_o,
  output wire        card_dma_unused_o
);

  // Shared (global) fields
  reg  [1:0] serial_irq_slot_step;
  reg        tie_irq_a_b;
  reg        tie_irq_a_b_c;
  reg        switch_clock_direction;
  reg        power_irq_route;
  reg        power_irq_enable;
  reg  [2:0] card_dma_channel;
  // Per-function (socket) fields
  reg  [1:0] power_irq_flag;
  reg  [1:0] spare_terminal_drive;
  reg  [1:0] vcc_guard_disable;
  reg  [1:0] reduced_zv;
  reg  [1:0] card_dma_request_enable;

  // Synchroniser stages for pin inputs
  reg  [1:0] pwr_sync_a;
  reg  [1:0] pwr_sync_b;
  reg  [1:0] ins_sync_a;
  reg  [1:0] ins_sync_b;
  reg  [1:0] dreq_sync_a;
  reg  [1:0] dreq_sync_b;
  reg  [2:0] int_sync_a;
  reg  [2:0] int_sync_b;

  // Working values
  reg  [1:0] next_power_irq_flag;
  reg  [2:0] merged;
  reg  [3:0] slots;

  // Write decode
  wire       hit    = cfg_addr_i == `BSC_SYSCTL_OFFSET;
  wire       wr_hi  = cfg_wr_i && hit && cfg_be_i[3];
  wire       wr_mid = cfg_wr_i && hit && cfg_be_i[2];
  wire [1:0] sel    = {cfg_func_i, ~cfg_func_i};
  wire [1:0] power_event = pwr_sync_b & {2{power_irq_enable}};

  // Rotate a 3-line set into 4 slots: step code 0 by none, codes 1 and 2 by one, code 3 by two
  function [3:0] bsc_step;
    input [2:0] lines;
    input [1:0] step;
    begin
      case (step)
        `BSC_STEP_NONE:  bsc_step = {1'b0, lines};
        `BSC_STEP_ONE_A: bsc_step = {lines, 1'b0};
        `BSC_STEP_ONE_B: bsc_step = {lines, 1'b0};
        `BSC_STEP_TWO:   bsc_step = {lines[1:0], 1'b0, lines[2]};
        default:         bsc_step = {1'b0, lines};
      endcase
    end
  endfunction

  // Power write events, two stages
  always @(posedge ref_clk_i)
  begin
    pwr_sync_a <= power_write_i;
    pwr_sync_b <= pwr_sync_a;
  end

  // Card inserted levels, two stages
  always @(posedge ref_clk_i)
  begin
    ins_sync_a <= cardbus_inserted_i;
    ins_sync_b <= ins_sync_a;
  end

  // Card DMA requests, two stages
  always @(posedge ref_clk_i)
  begin
    dreq_sync_a <= card_dreq_i;
    dreq_sync_b <= dreq_sync_a;
  end

  // Internal interrupt lines, two stages
  always @(posedge ref_clk_i)
  begin
    int_sync_a <= int_req_i;
    int_sync_b <= int_sync_a;
  end

  always @*
  begin
    // Write-one-clear; a new power event wins over the clear
    next_power_irq_flag = power_irq_flag;
    if (wr_hi && cfg_wdata_i[`BSC_FLAG_BIT])
    begin
      next_power_irq_flag = power_irq_flag & ~sel;
    end
    next_power_irq_flag = next_power_irq_flag | power_event;
  end

  // Global fields: one copy, written from either function
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      // Global reset only; no other reset source here
      serial_irq_slot_step   <= `BSC_STEP_RST;
      tie_irq_a_b            <= 1'b0;
      tie_irq_a_b_c          <= 1'b0;
      switch_clock_direction <= 1'b0;
      power_irq_route        <= 1'b0;
      power_irq_enable       <= 1'b0;
      card_dma_channel       <= `BSC_CHAN_RST;
    end
    else
    begin
      if (wr_hi)
      begin
        // Single shared copy
        serial_irq_slot_step   <=
          cfg_wdata_i[`BSC_STEP_HI:`BSC_STEP_LO];
        tie_irq_a_b            <= cfg_wdata_i[`BSC_TIE_AB_BIT];
        tie_irq_a_b_c          <= cfg_wdata_i[`BSC_TIE_ABC_BIT];
        switch_clock_direction <= cfg_wdata_i[`BSC_CLK_DIR_BIT];
        power_irq_route        <= cfg_wdata_i[`BSC_ROUTE_BIT];
        power_irq_enable       <= cfg_wdata_i[`BSC_ENABLE_BIT];
      end
      if (wr_mid)
      begin
        card_dma_channel <= cfg_wdata_i[`BSC_CHAN_HI:`BSC_CHAN_LO];
      end
    end
  end

  // Power interrupt flag per function
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      power_irq_flag <= 2'h0;
    end
    else
    begin
      power_irq_flag <= next_power_irq_flag;
    end
  end

  // Socket fields, one copy per function
  always @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      spare_terminal_drive    <= 2'h0;
      vcc_guard_disable       <= 2'h0;
      reduced_zv              <= 2'h0;
      card_dma_request_enable <= 2'h0;
    end
    else
    begin
      if (wr_mid && sel[0])
      begin
        spare_terminal_drive[0]    <= cfg_wdata_i[`BSC_SPARE_BIT];
        vcc_guard_disable[0]       <= cfg_wdata_i[`BSC_VCC_BIT];
        reduced_zv[0]              <= cfg_wdata_i[`BSC_ZV_BIT];
        card_dma_request_enable[0] <= cfg_wdata_i[`BSC_DREQ_EN_BIT];
      end
      if (wr_mid && sel[1])
      begin
        spare_terminal_drive[1]    <= cfg_wdata_i[`BSC_SPARE_BIT];
        vcc_guard_disable[1]       <= cfg_wdata_i[`BSC_VCC_BIT];
        reduced_zv[1]              <= cfg_wdata_i[`BSC_ZV_BIT];
        card_dma_request_enable[1] <= cfg_wdata_i[`BSC_DREQ_EN_BIT];
      end
    end
  end

  always @*
  begin
    cfg_rdata_o = 32'h0000_0000;
    if (hit)
    begin
      cfg_rdata_o[`BSC_STEP_HI:`BSC_STEP_LO] = serial_irq_slot_step;
      cfg_rdata_o[`BSC_TIE_AB_BIT]  = tie_irq_a_b;
      cfg_rdata_o[`BSC_TIE_ABC_BIT] = tie_irq_a_b_c;
      cfg_rdata_o[`BSC_CLK_DIR_BIT] = switch_clock_direction;
      cfg_rdata_o[`BSC_ROUTE_BIT]   = power_irq_route;
      cfg_rdata_o[`BSC_FLAG_BIT]    = power_irq_flag[cfg_func_i];
      cfg_rdata_o[`BSC_ENABLE_BIT]  = power_irq_enable;
      cfg_rdata_o[`BSC_RSVD23_BIT]  = 1'b0;
      cfg_rdata_o[`BSC_SPARE_BIT]   = spare_terminal_drive[cfg_func_i];
      cfg_rdata_o[`BSC_VCC_BIT]     = vcc_guard_disable[cfg_func_i];
      cfg_rdata_o[`BSC_ZV_BIT]      = reduced_zv[cfg_func_i];
      cfg_rdata_o[`BSC_DREQ_EN_BIT] = card_dma_request_enable[cfg_func_i];
      cfg_rdata_o[`BSC_CHAN_HI:`BSC_CHAN_LO] = card_dma_channel;
    end
  end

  // Merge internal lines before stepping them into slots
  always @*
  begin
    merged = int_sync_b;
    if (tie_irq_a_b_c)
    begin
      // All three lines onto INTA
      merged = {2'b00, |int_sync_b};
    end
    else if (tie_irq_a_b)
    begin
      // INTA and INTB onto INTA; INTC kept
      merged = {int_sync_b[2], 1'b0,
                int_sync_b[0] | int_sync_b[1]};
    end
    slots = bsc_step(merged, serial_irq_slot_step);
  end

  // Serial slot lines and the pin report: INTA alone when all three are tied, else all three lines
  assign serial_int_slot_o = slots;
  assign int_pin_report_o  = tie_irq_a_b_c ? `BSC_PIN_ALL_TIED
                                           : `BSC_PIN_ALL_LINES;

  // Drive oscillator out only when direction bit set
  assign switch_clock_oe_o = switch_clock_direction;
  assign switch_clock_o    = switch_clock_direction & osc_clk_i;

  // Power write interrupt, routed by the shared route bit
  assign irq2_power_o =
    power_event & {2{~power_irq_route}};
  assign card_status_change_irq_o =
    power_event & {2{power_irq_route}};

  // Socket pin controls
  assign spare_terminal_oe_o = spare_terminal_drive & ins_sync_b;
  assign vcc_guard_active_o  = ~vcc_guard_disable;
  assign card_addr_hi_oe_o   = ~reduced_zv;
  assign dma_request_o       =
    dreq_sync_b & card_dma_request_enable;

  // Channel assignment and its decode
  assign card_dma_channel_o = card_dma_channel;
  assign card_dma_unused_o  =
    card_dma_channel == `BSC_CHAN_PCI_MASTER;
  assign card_dma_16bit_o   =
    card_dma_channel > `BSC_CHAN_PCI_MASTER;

endmodule // bsc_sysctl_upper

// ==== core/bsc_defs.vh ====
// Offsets, field positions and reset values of the system control upper half
`ifndef BSC_DEFS_VH
`define BSC_DEFS_VH
`define BSC_SYSCTL_OFFSET   8'h80
`define BSC_STEP_HI         31
`define BSC_STEP_LO         30
`define BSC_TIE_AB_BIT      29
`define BSC_TIE_ABC_BIT     28
`define BSC_CLK_DIR_BIT     27
`define BSC_ROUTE_BIT       26
`define BSC_FLAG_BIT        25
`define BSC_ENABLE_BIT      24
`define BSC_RSVD23_BIT      23
`define BSC_SPARE_BIT       22
`define BSC_VCC_BIT         21
`define BSC_ZV_BIT          20
`define BSC_DREQ_EN_BIT     19
`define BSC_CHAN_HI         18
`define BSC_CHAN_LO         16
`define BSC_STEP_RST        2'h0
`define BSC_CHAN_RST        3'h4
`define BSC_STEP_NONE       2'h0
`define BSC_STEP_ONE_A      2'h1
`define BSC_STEP_ONE_B      2'h2
`define BSC_STEP_TWO        2'h3
`define BSC_CHAN_PCI_MASTER 3'h4
`define BSC_PIN_ALL_TIED    3'h1
`define BSC_PIN_ALL_LINES   3'h7
`endif

// ==== verif/bsc_checker_assertions.sv ====
// Port assertions for the system control upper half
`timescale 1ns/10ps
module bsc_checker
(
  input wire        ref_clk_i,
  input wire        rst_n_i,
  input wire [7:0]  cfg_addr_i,
  input wire        cfg_wr_i,
  input wire [3:0]  cfg_be_i,
  input wire [31:0] cfg_wdata_i,
  input wire [31:0] cfg_rdata_o,
  input wire [2:0]  int_pin_report_o,
  input wire        switch_clock_oe_o,
  input wire [1:0]  irq2_power_o,
  input wire [1:0]  card_status_change_irq_o,
  input wire [2:0]  card_dma_channel_o,
  input wire        card_dma_16bit_o,
  input wire        card_dma_unused_o
);
default clocking @(posedge ref_clk_i); endclocking
default disable iff (!rst_n_i);
wire sel = cfg_addr_i == 8'h80;
property p_oe; sel |-> switch_clock_oe_o == cfg_rdata_o[27]; endproperty
a_oe: assert property (p_oe) else $error("clock oe");
property p_pin; sel |-> int_pin_report_o == (cfg_rdata_o[28] ? 3'h1 : 3'h7);
endproperty
a_pin: assert property (p_pin) else $error("pin report");
property p_rsv; cfg_rdata_o[23] == 1'b0 && cfg_rdata_o[15:0] == 16'h0;
endproperty
a_rsv: assert property (p_rsv) else $error("reserved bits");
property p_dec; card_dma_unused_o == (card_dma_channel_o == 3'h4)
  && card_dma_16bit_o == (card_dma_channel_o > 3'h4); endproperty
a_dec: assert property (p_dec) else $error("channel decode");
property p_ch; sel |-> card_dma_channel_o == cfg_rdata_o[18:16]; endproperty
a_ch: assert property (p_ch) else $error("channel out");
property p_wr; sel && cfg_wr_i && cfg_be_i[3] ##1 sel
  |-> cfg_rdata_o[24] == $past(cfg_wdata_i[24]); endproperty
a_wr: assert property (p_wr) else $error("enable write");
property p_rst; $rose(rst_n_i) |-> card_dma_channel_o == 3'h4
  && !switch_clock_oe_o; endproperty
a_rst: assert property (p_rst) else $error("reset value");
property p_rt; (irq2_power_o & card_status_change_irq_o) == 2'h0; endproperty
a_rt: assert property (p_rt) else $error("route clash");
endmodule // bsc_checker

// ==== verif/bsc_socket_model.sv ====
// Socket side model: free oscillator and power-write events
`timescale 1ns/10ps
module bsc_socket_model
(
  input  wire       ref_clk_i,
  input  wire [1:0] pw_go_i,
  output reg        osc_clk_o,
  output reg  [1:0] power_write_o
);
initial osc_clk_o = 1'b0;
always #37 osc_clk_o = ~osc_clk_o;
initial power_write_o = 2'h0;
always @(posedge ref_clk_i) power_write_o <= pw_go_i;
endmodule // bsc_socket_model

// ==== verif/bridge_sysctl_upper_config_bench.sv ====
// Self-checking bench for the system control upper half
`timescale 1ns/10ps
module bridge_sysctl_upper_config_bench;
reg         ref_clk_i, rst_n_i, cfg_func_i, cfg_wr_i;
reg  [7:0]  cfg_addr_i;
reg  [3:0]  cfg_be_i;
reg  [31:0] cfg_wdata_i;
reg  [2:0]  int_req_i;
reg  [1:0]  pw_go, seen;
wire [31:0] cfg_rdata_o;
wire [3:0]  slot;
wire [1:0]  pw, irq2, card_status_change_irq, spare, vcc, ahi, dma;
wire        osc, sclk;
reg  [35:0] rows [0:7];
integer     n_fail = 0, checked = 0, cyc = 0, i;
bsc_socket_model sock (.ref_clk_i, .pw_go_i(pw_go), .osc_clk_o(osc),
  .power_write_o(pw));
bsc_sysctl_upper uut (.ref_clk_i, .rst_n_i, .cfg_addr_i, .cfg_func_i,
  .cfg_wr_i, .cfg_be_i, .cfg_wdata_i, .cfg_rdata_o, .int_req_i,
  .serial_int_slot_o(slot), .int_pin_report_o(), .switch_clock_o(sclk),
  .switch_clock_oe_o(), .osc_clk_i(osc), .power_write_i(pw),
  .irq2_power_o(irq2), .card_status_change_irq_o(card_status_change_irq),
  .cardbus_inserted_i(2'h1), .spare_terminal_oe_o(spare),
  .vcc_guard_active_o(vcc), .card_addr_hi_oe_o(ahi), .card_dreq_i(2'h1),
  .dma_request_o(dma), .card_dma_channel_o(), .card_dma_16bit_o(),
  .card_dma_unused_o());
task chk(input [31:0] got, input [31:0] exp);
begin
  checked = checked + 1;
  if (got !== exp)
  begin
    n_fail = n_fail + 1;
    $display("wrong value at %0t: got %h expected %h", $time, got, exp);
  end
end
endtask
task tick(input integer n);
begin
  repeat (n) @(posedge ref_clk_i);
  #1;
end
endtask
task w(input [3:0] be, input [31:0] d);
begin
  cfg_be_i = be;
  cfg_wdata_i = d;
  cfg_wr_i = 1'b1;
  tick(1);
  cfg_wr_i = 1'b0;
  tick(1);
end
endtask
task pulse;
begin
  pw_go = 2'h1;
  tick(1);
  pw_go = 2'h0;
  seen = 2'h0;
  repeat (8)
  begin
    tick(1);
    seen = seen | {card_status_change_irq[0], irq2[0]};
  end
end
endtask
task end_sim;
begin
  $display("compares %0d mismatches %0d", checked, n_fail);
  if (n_fail == 0 && checked > 0)
    $display("Regression OK");
  else
    $display("Regression broken");
  $finish;
end
endtask
initial
begin
  ref_clk_i = 1'b0;
  forever #50 ref_clk_i = ~ref_clk_i;
end
always @(posedge ref_clk_i)
begin
  cyc = cyc + 1;
  if (cyc == 2000)
  begin
    n_fail = n_fail + 1;
    end_sim;
  end
end
initial
begin
  {rst_n_i, cfg_func_i, cfg_wr_i, cfg_be_i, cfg_wdata_i, pw_go} = 0;
  cfg_addr_i = 8'h80;
  int_req_i = 3'h2;
  // Write data beside the expected slot lines for INTB alone
  rows[0] = 36'h0000_0000_2;
  rows[1] = 36'h4000_0000_4;
  rows[2] = 36'h8000_0000_4;
  rows[3] = 36'hc000_0000_8;
  rows[4] = 36'h2000_0000_1;
  rows[5] = 36'hd000_0000_4;
  rows[6] = 36'hffff_ffff_4;
  rows[7] = 36'haaaa_aaaa_2;
  tick(4);
  rst_n_i = 1'b1;
  for (i = 0; i < 8; i = i + 1)
  begin
    w(4'hc, rows[i][35:4]);
    chk(cfg_rdata_o, rows[i][35:4] & 32'hfd7f_0000);
    chk({28'h0, slot}, {28'h0, rows[i][3:0]});
    $display("row %0d done", i);
  end
  rst_n_i = 1'b0;
  tick(4);
  rst_n_i = 1'b1;
  chk(cfg_rdata_o, 32'h0004_0000);
  chk({31'h0, sclk}, 32'h0);
  chk({spare[0], vcc[0], ahi[0], dma[0]}, 32'h6);
  w(4'h4, 32'h0078_0000);
  chk({spare[0], vcc[0], ahi[0], dma[0]}, 32'h9);
  w(4'h8, 32'h0100_0000);
  pulse;
  chk(seen, 32'h1);
  chk(cfg_rdata_o, 32'h0378_0000);
  w(4'h8, 32'h0300_0000);
  chk(cfg_rdata_o, 32'h0178_0000);
  cfg_func_i = 1'b1;
  #1;
  chk(cfg_rdata_o, 32'h0100_0000);
  cfg_func_i = 1'b0;
  w(4'h8, 32'h0500_0000);
  pulse;
  chk(seen, 32'h2);
  cfg_addr_i = 8'h84;
  w(4'hf, 32'hffff_ffff);
  chk(cfg_rdata_o, 32'h0);
  cfg_addr_i = 8'h80;
  #1;
  chk(cfg_rdata_o, 32'h0778_0000);
  $display("hand tests done");
  end_sim;
end
endmodule // bridge_sysctl_upper_config_bench
bind bsc_sysctl_upper bsc_checker chk_i (.ref_clk_i, .rst_n_i, .cfg_addr_i,
  .cfg_wr_i, .cfg_be_i, .cfg_wdata_i, .cfg_rdata_o, .int_pin_report_o,
  .switch_clock_oe_o, .irq2_power_o, .card_status_change_irq_o,
  .card_dma_channel_o, .card_dma_16bit_o, .card_dma_unused_o);
